// ### include/cmpc_pkg.sv
// constants for the dual comparator control block
// assumes a 32-bit classic wishbone bus with byte addresses
package cmpc_pkg;
	// number of comparator channels
	localparam int NUM_CH = 2;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_CH_STRIDE = 8'h08;
	localparam logic [7:0] OFS_MIRROR = 8'h10;
	localparam logic [7:0] OFS_FLAGS = 8'h14;
	localparam logic [7:0] OFS_IRQEN = 8'h18;
	// comparator_control_0 fields
	localparam int C0_ENABLE = 7;
	localparam int C0_RESULT = 6;
	localparam int C0_PIN_OE = 5;
	localparam int C0_INVERT = 4;
	localparam int C0_SPEED = 2;
	localparam int C0_HYST = 1;
	localparam int C0_SYNC = 0;
	// comparator_control_1 fields
	localparam int C1_RISE_IE = 7;
	localparam int C1_FALL_IE = 6;
	localparam int C1_POS_LSB = 4;
	localparam int C1_NEG_LSB = 0;
	localparam int POS_W = 2;
	localparam int NEG_W = 3;
	// highest legal inverting input code, the fixed reference
	localparam logic [2:0] NEG_FIXED = 3'h4;
	// interrupt enable register fields
	localparam int IE_PERIPH = 6;
	localparam int IE_GLOBAL = 7;
	// reset values and writable masks
	localparam logic [7:0] CTRL0_RST = 8'h04;
	localparam logic [7:0] CTRL0_WMASK = 8'hB7;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL1_WMASK = 8'hF7;
	localparam logic [7:0] IRQEN_RST = 8'h00;
	localparam logic [7:0] IRQEN_WMASK = 8'hC3;
endpackage

// ### include/cmpc_chan_if.sv
// per-channel link between the register file and a channel core
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface cmpc_chan_if;
	logic en; // channel enabled
	logic inv; // invert result
	logic sync; // capture on timer clock
	logic tmr_fall; // falling edge of prescaled timer clock
	logic result; // registered result bit
	logic gate; // result towards timer gate and pin
	logic rise; // result went low to high
	logic fall; // result went high to low
	modport ctrl (output en, inv, sync, tmr_fall, input result, gate, rise, fall);
	modport chan (input en, inv, sync, tmr_fall, output result, gate, rise, fall);
endinterface

// ### rtl/cmpc_channel.sv
// one comparator channel: synchroniser, polarity, edges, timer capture
// assumes raw_i is asynchronous and tmr_fall is a one-cycle pulse
`timescale 1ns/1ps
module cmpc_channel (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic raw_i,
	cmpc_chan_if.chan ch
);
	logic sync1_r; // first synchroniser stage
	logic sync2_r; // second synchroniser stage
	logic result_r; // output bit as software sees it
	logic prev_r; // result one cycle earlier
	logic gate_r; // value for timer gate and pin
	logic core;

	// two-stage synchroniser on the analog result
	always_ff @(posedge clk_i)
	begin
		sync1_r <= raw_i;
		sync2_r <= sync1_r;
	end

	// a disabled core reads low, the invert still applies
	assign core = ch.en ? sync2_r : 1'b0;

	// result registered once per clock
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			result_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			result_r <= core ^ ch.inv;
			prev_r <= result_r;
		end
	end

	// gate value: captured on timer falling edge or passed each clock
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			gate_r <= 1'b0;
		else if (!ch.sync)
			gate_r <= result_r;
		else if (ch.tmr_fall)
			gate_r <= result_r;
	end

	assign ch.result = result_r;
	assign ch.gate = gate_r;
	assign ch.rise = result_r && !prev_r;
	assign ch.fall = !result_r && prev_r;

	a_raw_latency: assert property (@(posedge clk_i) disable iff (rst_i)
		(ch.en && !ch.inv)[*3] |-> result_r == $past(raw_i, 3))
		else $error("result does not follow raw input");
	a_off_inverted: assert property (@(posedge clk_i) disable iff (rst_i)
		!ch.en && ch.inv |=> result_r)
		else $error("disabled inverted channel not high");
	a_async_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		!ch.sync |=> gate_r == $past(result_r))
		else $error("gate not passing result");
	a_sync_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		ch.sync && !ch.tmr_fall |=> $stable(gate_r))
		else $error("gate moved without timer edge");
	// the capture itself must take the result, not only hold still
	a_sync_capture: assert property (@(posedge clk_i) disable iff (rst_i)
		ch.sync && ch.tmr_fall |=> gate_r == $past(result_r))
		else $error("gate missed a timer capture");
	c_sync_capture: cover property (@(posedge clk_i) disable iff (rst_i)
		ch.sync && ch.tmr_fall && (gate_r != result_r));
endmodule

// ### rtl/cmpc_top.sv
// dual comparator control: wishbone registers and two channel cores
// assumes tmr_clk_i is the prescaled timer clock, synchronous to clk_i
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module cmpc_top #(
	parameter int ADR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] cmp_raw_i,
	input wire logic tmr_clk_i,
	input wire logic [1:0] pin_direction_bit_i,
	output logic [1:0] gate_o,
	output logic [1:0] pin_o,
	output logic [1:0] pin_oe_o,
	output logic [1:0] core_on_o,
	output logic [1:0] speed_o,
	output logic [1:0] hyst_o,
	output logic [3:0] pos_sel_o,
	output logic [5:0] neg_sel_o,
	output logic [1:0] noninv_connect_o,
	output logic [1:0] inv_connect_o,
	output logic irq_o
);
	localparam int N = cmpc_pkg::NUM_CH;

	logic [7:0] ctrl0_r [N]; // comparator_control_0 stored bits
	logic [7:0] ctrl1_r [N]; // comparator_control_1
	logic [7:0] irqen_r; // channel, peripheral and global enables
	logic [N-1:0] flag_r; // sticky edge flags
	logic [N-1:0] pin_oe_r; // pin drive enables
	logic [N-1:0] nconn_r; // non-inverting input connected
	logic [N-1:0] iconn_r; // inverting input connected
	logic [N-1:0] result_w; // result bits from the cores
	logic [N-1:0] gate_w; // gate values from the cores
	logic [N-1:0] set_w; // edge events that set a flag
	logic [N-1:0] clr_w; // software clears of a flag
	logic tmr_prev_r; // timer clock one cycle earlier
	logic tmr_fall; // timer clock falling edge pulse
	logic ack_r; // wishbone acknowledge
	logic [31:0] dat_r; // wishbone read data
	logic [31:0] rd_data; // read mux result
	logic irq_r; // gated interrupt request
	logic req; // new request seen
	logic wr_go; // write takes effect this edge
	logic [7:0] wdat; // low byte of write data

	cmpc_chan_if ch_if [N] ();

	// request valid and not yet answered
	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	// write commits at the edge where the master sees ack
	assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
	assign wdat = wb_dat_i[7:0];

	// single-cycle acknowledge, dropped the cycle after
	// a request is taken only while no ack is out, so it is answered once
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= req;
	end

	// read data captured with the acknowledge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= 32'h0000_0000;
		else if (req)
			dat_r <= rd_data;
	end

	// read mux, unmapped offsets read zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		for (int k = 0; k < N; k++)
		begin
			// result bit sits in place of the stored bit
			if (wb_adr_i == ADR_W'(cmpc_pkg::OFS_CTRL0 + 8'(k) * cmpc_pkg::OFS_CH_STRIDE))
			begin
				rd_data[7:0] = ctrl0_r[k] & cmpc_pkg::CTRL0_WMASK;
				rd_data[cmpc_pkg::C0_RESULT] = result_w[k];
			end
			if (wb_adr_i == ADR_W'(cmpc_pkg::OFS_CTRL1 + 8'(k) * cmpc_pkg::OFS_CH_STRIDE))
				rd_data[7:0] = ctrl1_r[k] & cmpc_pkg::CTRL1_WMASK;
		end
		// mirror of both result bits, upper bits zero
		if (wb_adr_i == ADR_W'(cmpc_pkg::OFS_MIRROR))
			rd_data[N-1:0] = result_w;
		// sticky edge flags
		if (wb_adr_i == ADR_W'(cmpc_pkg::OFS_FLAGS))
			rd_data[N-1:0] = flag_r;
		// channel, peripheral and global enables
		if (wb_adr_i == ADR_W'(cmpc_pkg::OFS_IRQEN))
			rd_data[7:0] = irqen_r & cmpc_pkg::IRQEN_WMASK;
	end

	// interrupt enable register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irqen_r <= cmpc_pkg::IRQEN_RST;
		else if (wr_go && wb_adr_i == ADR_W'(cmpc_pkg::OFS_IRQEN))
			irqen_r <= wdat & cmpc_pkg::IRQEN_WMASK;
	end

	// falling edge of the prescaled timer clock; the timer counts on
	// the rising edge, so capturing here avoids a race
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tmr_prev_r <= 1'b0;
		else
			tmr_prev_r <= tmr_clk_i;
	end
	assign tmr_fall = tmr_prev_r && !tmr_clk_i;

	// per-channel registers, flags and cores
	for (genvar g = 0; g < N; g++)
	begin : g_ch
		localparam logic [ADR_W-1:0] A_C0 =
			ADR_W'(cmpc_pkg::OFS_CTRL0 + 8'(g) * cmpc_pkg::OFS_CH_STRIDE);
		localparam logic [ADR_W-1:0] A_C1 =
			ADR_W'(cmpc_pkg::OFS_CTRL1 + 8'(g) * cmpc_pkg::OFS_CH_STRIDE);
		logic [2:0] neg;

		// control register 0, result bit is read-only
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				ctrl0_r[g] <= cmpc_pkg::CTRL0_RST;
			else if (wr_go && wb_adr_i == A_C0)
				ctrl0_r[g] <= wdat & cmpc_pkg::CTRL0_WMASK;
		end

		// control register 1
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				ctrl1_r[g] <= cmpc_pkg::CTRL1_RST;
			else if (wr_go && wb_adr_i == A_C1)
				ctrl1_r[g] <= wdat & cmpc_pkg::CTRL1_WMASK;
		end

		// drive the core from the control bits
		assign ch_if[g].en = ctrl0_r[g][cmpc_pkg::C0_ENABLE];
		assign ch_if[g].inv = ctrl0_r[g][cmpc_pkg::C0_INVERT];
		assign ch_if[g].sync = ctrl0_r[g][cmpc_pkg::C0_SYNC];
		assign ch_if[g].tmr_fall = tmr_fall;
		assign result_w[g] = ch_if[g].result;
		assign gate_w[g] = ch_if[g].gate;

		cmpc_channel u_ch (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.raw_i(cmp_raw_i[g]),
			.ch(ch_if[g])
		);

		// edge events gated by their enables
		assign set_w[g] = (ch_if[g].rise && ctrl1_r[g][cmpc_pkg::C1_RISE_IE])
			|| (ch_if[g].fall && ctrl1_r[g][cmpc_pkg::C1_FALL_IE]);
		// write one to clear a flag
		assign clr_w[g] = wr_go && wb_adr_i == ADR_W'(cmpc_pkg::OFS_FLAGS) && wdat[g];

		// sticky flag, a new edge wins over a clear
		// edge logic never clears it, only a software write or reset does
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				flag_r[g] <= 1'b0;
			else
				flag_r[g] <= (flag_r[g] && !clr_w[g]) || set_w[g];
		end

		// pin drive and input connection
		assign neg = ctrl1_r[g][cmpc_pkg::C1_NEG_LSB +: cmpc_pkg::NEG_W];
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				pin_oe_r[g] <= 1'b0;
				nconn_r[g] <= 1'b0;
				iconn_r[g] <= 1'b0;
			end
			else
			begin
				// enable bit plays no part in pin routing
				pin_oe_r[g] <= ctrl0_r[g][cmpc_pkg::C0_PIN_OE]
					&& !pin_direction_bit_i[g];
				nconn_r[g] <= ch_if[g].en;
				// reserved minus codes leave the input open
				iconn_r[g] <= ch_if[g].en && (neg <= cmpc_pkg::NEG_FIXED);
			end
		end

		// analog settings straight from the registers
		assign core_on_o[g] = ctrl0_r[g][cmpc_pkg::C0_ENABLE];
		assign speed_o[g] = ctrl0_r[g][cmpc_pkg::C0_SPEED];
		assign hyst_o[g] = ctrl0_r[g][cmpc_pkg::C0_HYST];
		assign pos_sel_o[g*2 +: 2] =
			ctrl1_r[g][cmpc_pkg::C1_POS_LSB +: cmpc_pkg::POS_W];
		assign neg_sel_o[g*3 +: 3] = neg;

		// checks for this channel: enabled edges set the flag
		a_rise_flag: assert property (@(posedge clk_i) disable iff (rst_i)
			ch_if[g].rise && ctrl1_r[g][cmpc_pkg::C1_RISE_IE] |=> flag_r[g])
			else $error("rising edge did not set flag");
		a_fall_flag: assert property (@(posedge clk_i) disable iff (rst_i)
			ch_if[g].fall && ctrl1_r[g][cmpc_pkg::C1_FALL_IE] |=> flag_r[g])
			else $error("falling edge did not set flag");
		a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
			flag_r[g] && !clr_w[g] |=> flag_r[g])
			else $error("flag dropped without clear");
		a_no_edge_set: assert property (@(posedge clk_i) disable iff (rst_i)
			!flag_r[g] && !set_w[g] |=> !flag_r[g])
			else $error("flag set without enabled edge");

		// an edge in the cycle of the clear keeps the flag set
		a_set_beats_clr: assert property (@(posedge clk_i) disable iff (rst_i)
			set_w[g] && clr_w[g] |=> flag_r[g])
			else $error("clear won over a new edge");
		// a clear with no edge empties the flag
		a_clr_empties: assert property (@(posedge clk_i) disable iff (rst_i)
			clr_w[g] && !set_w[g] |=> !flag_r[g])
			else $error("flag survived its clear");

		// pin drive follows its enable and the direction bit both ways
		a_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
			pin_oe_o[g] |-> $past(ctrl0_r[g][cmpc_pkg::C0_PIN_OE])
				&& !$past(pin_direction_bit_i[g]))
			else $error("pin driven without enable");
		a_pin_on: assert property (@(posedge clk_i) disable iff (rst_i)
			ctrl0_r[g][cmpc_pkg::C0_PIN_OE] && !pin_direction_bit_i[g] |=> pin_oe_o[g])
			else $error("enabled pin not driven");

		// input switches: open when disabled, reserved codes always open
		a_input_off: assert property (@(posedge clk_i) disable iff (rst_i)
			!ch_if[g].en |=> !noninv_connect_o[g] && !inv_connect_o[g])
			else $error("disabled channel input connected");
		a_input_on: assert property (@(posedge clk_i) disable iff (rst_i)
			ch_if[g].en |=> noninv_connect_o[g])
			else $error("enabled channel plus input open");
		a_neg_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
			neg > cmpc_pkg::NEG_FIXED |=> !inv_connect_o[g])
			else $error("reserved minus code connected");
		a_neg_legal: assert property (@(posedge clk_i) disable iff (rst_i)
			ch_if[g].en && neg <= cmpc_pkg::NEG_FIXED |=> inv_connect_o[g])
			else $error("legal minus code left open");

		// control bits leave reset with normal speed and the core off
		a_speed_reset: assert property (@(posedge clk_i)
			$fell(rst_i) |-> speed_o[g] && !core_on_o[g])
			else $error("control reset value wrong");
		c_flag_set: cover property (@(posedge clk_i) disable iff (rst_i)
			$rose(flag_r[g]));
	end

	// interrupt request needs an enabled flag and both global enables
	// channel enables sit in the low bits, beside the two global ones
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_r <= 1'b0;
		else
			irq_r <= |(flag_r & irqen_r[N-1:0])
				&& irqen_r[cmpc_pkg::IE_PERIPH]
				&& irqen_r[cmpc_pkg::IE_GLOBAL];
	end

	// every output below comes straight from a flop
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign gate_o = gate_w;
	assign pin_o = gate_w;
	assign pin_oe_o = pin_oe_r;
	assign noninv_connect_o = nconn_r;
	assign inv_connect_o = iconn_r;
	assign irq_o = irq_r;

	// bus checks: one ack per request, nothing above the byte lane
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> wb_ack_o)
		else $error("request left unanswered");
	a_idle_no_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_cyc_i |=> !wb_ack_o)
		else $error("ack without a cycle");
	a_read_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("read data above the byte not zero");
	a_mirror_read: assert property (@(posedge clk_i) disable iff (rst_i)
		req && wb_adr_i == ADR_W'(cmpc_pkg::OFS_MIRROR)
			|=> wb_dat_o == {30'h0000_0000, $past(result_w)})
		else $error("mirror read wrong");

	// interrupt checks: both global enables and at least one enabled flag
	a_irq_global: assert property (@(posedge clk_i) disable iff (rst_i)
		!irqen_r[cmpc_pkg::IE_GLOBAL] || !irqen_r[cmpc_pkg::IE_PERIPH] |=> !irq_o)
		else $error("irq without global enables");
	a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_r[0] && irqen_r[0] && irqen_r[cmpc_pkg::IE_PERIPH]
			&& irqen_r[cmpc_pkg::IE_GLOBAL] |=> irq_o)
		else $error("enabled flag gave no irq");
	a_irq_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|(flag_r & irqen_r[N-1:0])) |=> !irq_o)
		else $error("irq without an enabled flag");

	// main scenarios: an interrupt, a write, a mirror read
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
	c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_go);
	c_read_mirror: cover property (@(posedge clk_i) disable iff (rst_i)
		req && !wb_we_i && wb_adr_i == ADR_W'(cmpc_pkg::OFS_MIRROR));
endmodule

// ### bench/cmpc_far_model.sv
// far side model: analog compare core and prescaled timer clock
// assumes the bench sets the analog relation and starts the timer
`timescale 1ns/1ps
module cmpc_far_model #(
	parameter int DIV = 3
) (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [1:0] level_i,
	output logic [1:0] raw_o,
	output logic tmr_clk_o
);
	int cnt; // prescaler count
	// compare result follows the analog relation, no clock relation
	assign raw_o = level_i;
	// prescaled timer clock, held low while the timer is stopped
	always_ff @(posedge clk_i)
	begin
		if (!run_i)
		begin
			cnt <= 0;
			tmr_clk_o <= 1'b0;
		end
		else if (cnt == DIV)
		begin
			cnt <= 0;
			tmr_clk_o <= !tmr_clk_o;
		end
		else
			cnt <= cnt + 1;
	end
endmodule

// ### bench/cmpc_top_tb.sv
// self-checking bench for the dual comparator control block
// assumes the far side model drives raw results and the timer clock
`timescale 1ns/1ps
module cmpc_top_tb;
	logic clk_i, rst_i, cyc, stb, we, run, tclk, ack, irq;
	logic [7:0] adr;
	logic [31:0] wdat, rdat;
	logic [3:0] sel, psel;
	logic [5:0] nsel;
	logic [1:0] lvl, dir, raw, gate, pin, oe, on, spd, hyst, ncon, icon;
	logic [7:0] ie_tab [4] = '{8'h43, 8'h83, 8'hC2, 8'hC1}; // irq enable sets
	logic [7:0] rst_tab [7] = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
	int err_total, checks;
	cmpc_far_model #(.DIV(3)) i_far (.clk_i(clk_i), .run_i(run), .level_i(lvl),
		.raw_o(raw), .tmr_clk_o(tclk));
	cmpc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(ack), .cmp_raw_i(raw), .tmr_clk_i(tclk), .pin_direction_bit_i(dir),
		.gate_o(gate), .pin_o(pin), .pin_oe_o(oe), .core_on_o(on), .speed_o(spd),
		.hyst_o(hyst), .pos_sel_o(psel), .neg_sel_o(nsel), .noninv_connect_o(ncon),
		.inv_connect_o(icon), .irq_o(irq));
	// compare one value and count it
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one classic wishbone cycle, held until ack is seen
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= 32'(d);
		@(posedge clk_i);
		// no local limit: the hang guard ends a wait that never sees ack
		while (ack !== 1'b1)
			@(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask
	// register read compared with its expected byte
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [31:0] q;
		wb(a, 1'b0, 8'h00, q);
		chk(what, q, 32'(exp));
	endtask
	// wait a number of clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// free running bus clock
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = !clk_i;
	end
	// hang guard
	initial
	begin
		#200000;
		err_total++;
		tally_and_finish();
	end
	// main sequence
	initial
	begin
		{cyc, stb, we, run, adr, wdat, lvl, dir} = '0;
		sel = 4'hF;
		rst_i = 1'b1;
		err_total = 0;
		checks = 0;
		tick(6);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(8'(4 * i), rst_tab[i], "reset value");
		chk("speed", 32'(spd), 32'h3);
		rd(8'h1C, 8'h00, "unmapped");
		// channel one on, rising edge flag
		wr(8'h04, 8'h80);
		wr(8'h00, 8'hA2);
		lvl <= 2'b01;
		tick(8);
		rd(8'h00, 8'hE2, "ctrl0 result");
		rd(8'h10, 8'h01, "mirror");
		rd(8'h14, 8'h01, "rise flag");
		chk("on", 32'(on), 32'h1);
		chk("hyst", 32'(hyst), 32'h1);
		chk("speed low", 32'(spd), 32'h2);
		chk("pin oe", 32'(oe), 32'h1);
		chk("gate", 32'({pin, gate}), 32'h5);
		// a missing global, peripheral or channel one enable blocks the request
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h18, ie_tab[i]);
			tick(2);
			chk("irq", 32'(irq), 32'(i == 3));
		end
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h00, "flag clear");
		// inverted result, falling edge flag only
		wr(8'h00, 8'hB2);
		tick(3);
		rd(8'h14, 8'h00, "fall not enabled");
		wr(8'h04, 8'h40);
		lvl <= 2'b00;
		tick(6);
		rd(8'h14, 8'h00, "rise not enabled");
		lvl <= 2'b01;
		tick(6);
		rd(8'h14, 8'h01, "fall flag");
		dir <= 2'b01;
		tick(3);
		chk("pin oe dir", 32'(oe), 32'h0);
		// a fall lands in the very cycle in which the clear commits
		lvl <= 2'b00;
		tick(6);
		lvl <= 2'b01;
		tick(1);
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h01, "set beats clear");
		// disabled channel: inputs cut, invert still gives an edge
		wr(8'h14, 8'h01);
		wr(8'h04, 8'hC0);
		wr(8'h00, 8'h00);
		tick(3);
		chk("connect", 32'({ncon[0], icon[0]}), 32'h0);
		rd(8'h14, 8'h00, "no edge");
		wr(8'h00, 8'h10);
		tick(4);
		rd(8'h14, 8'h01, "invert edge");
		rd(8'h00, 8'h50, "disabled result");
		// channel two input selects, every code
		wr(8'h08, 8'h80);
		for (int p = 0; p < 4; p++)
			for (int n = 0; n < 8; n++)
			begin
				wr(8'h0C, 8'((p << 4) | n));
				tick(2);
				chk("sel", 32'({psel[3:2], nsel[5:3]}), 32'((p << 3) | n));
				chk("inv connect", 32'(icon[1]), 32'(n <= 4));
				chk("plus connect", 32'(ncon[1]), 32'h1);
			end
		// sync mode: gate waits for a timer falling edge
		wr(8'h08, 8'h81);
		lvl <= 2'b11;
		tick(8);
		chk("gate held", 32'(gate[1]), 32'h0);
		run <= 1'b1;
		tick(20);
		chk("gate synced", 32'({pin[1], gate[1]}), 32'h3);
		tally_and_finish();
	end
endmodule
